// >>> verilog/stc_top.sv
// Start-up timer, clock-ready status and clock output with register slave
//
// What this block does
// - Start-up timer runs 7500 oscillator cycles.
// - Registers stay accessible while timer runs.
// - Expiry sets clock-ready flag; host polls it.
// - Output low until expiry, then divide by 4.
// - Soft or pin reset keeps output configuration.
// - Output runs through power-down; timer restarts after.
// - Select zero disables output, pin driven low.
// - No pulse shorter than configured phase width, except when a test select (11x) cuts a phase.
// - Switching leaves a low gap of 4-8 periods.
// - Select decode: off, 1,2,3,4,8; 11x test.
//
// Added by the designer: the Avalon-MM interface to the registers and the register offsets.
module stc_top #(
  parameter int unsigned STARTUP_OSC_CYCLES = stc_pkg::STARTUP_OSC_CYCLES,
  parameter int unsigned STARTUP_CNT_W      = 14
) (
  // Clock and power-on reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Avalon-MM register slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Device reset pin, synchronous to clock
  input  wire logic        device_reset_n,
  // Clock output pin and interrupt
  output logic             clock_output_pin,
  output logic             irq
);

  if (STARTUP_OSC_CYCLES < 1 ||
      STARTUP_OSC_CYCLES > (1 << STARTUP_CNT_W)) begin : g_bad_startup
    $error("Start-up count does not fit its counter");
  end

  localparam logic [STARTUP_CNT_W-1:0] STARTUP_LAST =
    STARTUP_CNT_W'(STARTUP_OSC_CYCLES - 1);

  stc_clk_if clk_link ();

  // Register state
  logic [2:0]           clock_output_control_reg;
  logic                 power_down_reg;
  logic                 power_down_prev_reg;
  logic                 soft_reset_reg;
  logic [stc_pkg::IRQ_W-1:0] irq_status_reg;
  logic [stc_pkg::IRQ_W-1:0] irq_mask_reg;
  logic                 irq_reg;
  logic                 wait_reg;
  logic [31:0]          readdata_reg;

  // Start-up timer state
  logic                     osc_phase_reg;
  logic [STARTUP_CNT_W-1:0] startup_cnt_reg;
  logic                     clock_ready_reg;
  logic                     clock_ready_prev_reg;
  logic                     allow_reg;
  logic                     busy_prev_reg;

  // Decoded strobes
  logic                       access_go;
  logic                       wr_go;
  logic                       dev_reset;
  logic                       timer_restart;
  logic                       osc_tick;
  logic [stc_pkg::IRQ_W-1:0]  irq_set;
  logic [stc_pkg::IRQ_W-1:0]  irq_clear;
  logic [stc_pkg::IRQ_W-1:0]  irq_status_next;
  logic [stc_pkg::IRQ_W-1:0]  irq_mask_next;
  logic [2:0]                 clock_output_control_next;
  logic                       power_down_next;
  logic                       wait_next;
  logic [31:0]                readdata_next;
  logic                       startup_last;

  if (STARTUP_CNT_W < 1 || STARTUP_CNT_W > 30) begin : g_bad_width
    $error("Start-up counter width out of range");
  end

  if (stc_pkg::CLOCKS_PER_OSC != 2) begin : g_bad_osc
    $error("Oscillator enable assumes two clocks per period");
  end

  // Register address match
  function automatic logic hit(
    input logic [4:0] addr,
    input logic [4:0] offset
  );
    hit = (addr == offset);
  endfunction

  // Interrupt field of a write, low byte lane only
  function automatic logic [stc_pkg::IRQ_W-1:0] irq_field(
    input logic [31:0] data,
    input logic [3:0]  lanes
  );
    irq_field = lanes[0] ? data[stc_pkg::IRQ_W-1:0] : '0;
  endfunction

  // Status word: ready, gap busy and the select in effect
  function automatic logic [31:0] status_word(
    input logic       ready,
    input logic       busy,
    input logic [2:0] active
  );
    status_word                                = 32'h0;
    status_word[stc_pkg::STAT_READY_BIT]       = ready;
    status_word[stc_pkg::STAT_BUSY_BIT]        = busy;
    status_word[stc_pkg::STAT_ACTIVE_LSB +: 3] = active;
  endfunction

  // Bus strobes: a transfer completes while waitrequest is low
  assign access_go = (avs_read || avs_write) && !wait_reg;
  assign wr_go     = avs_write && !wait_reg && avs_byteenable[0];

  // Pin reset and software reset act alike
  assign dev_reset = !device_reset_n || soft_reset_reg;

  // Leaving power-down restarts the timer
  assign timer_restart = power_down_prev_reg && !power_down_reg;

  // One oscillator period per two system clocks
  assign osc_tick     = osc_phase_reg;
  assign startup_last = (startup_cnt_reg == STARTUP_LAST);

  // Oscillator-rate enable
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      osc_phase_reg <= 1'b0;
    end else begin
      osc_phase_reg <= !osc_phase_reg;
    end
  end

  // Start-up timer, held at zero during power-down
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      startup_cnt_reg <= '0;
    end else if (timer_restart || power_down_reg) begin
      startup_cnt_reg <= '0;
    end else if (osc_tick && !clock_ready_reg && !startup_last) begin
      startup_cnt_reg <= startup_cnt_reg + 1'b1;
    end
  end

  // Clock-ready flag
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clock_ready_reg <= 1'b0;
    end else if (timer_restart) begin
      clock_ready_reg <= 1'b0;
    end else if (osc_tick && startup_last && !power_down_reg) begin
      clock_ready_reg <= 1'b1;
    end
  end

  // Delayed copies for edge detection
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clock_ready_prev_reg <= 1'b0;
      busy_prev_reg        <= 1'b0;
      power_down_prev_reg  <= 1'b0;
    end else begin
      clock_ready_prev_reg <= clock_ready_reg;
      busy_prev_reg        <= clk_link.busy;
      power_down_prev_reg  <= power_down_reg;
    end
  end

  // Output may run once the first start-up delay has passed
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      allow_reg <= 1'b0;
    end else if (clock_ready_reg) begin
      allow_reg <= 1'b1;
    end
  end

  // Output select: only power-on reset restores the default
  always_comb begin
    clock_output_control_next = clock_output_control_reg;
    if (wr_go && hit(avs_address, stc_pkg::OFF_CLOCK_OUTPUT_PIN_CTRL)) begin
      clock_output_control_next = avs_writedata[2:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clock_output_control_reg <= stc_pkg::SEL_RESET;
    end else begin
      clock_output_control_reg <= clock_output_control_next;
    end
  end

  // Power control
  always_comb begin
    power_down_next = power_down_reg;
    if (dev_reset) begin
      power_down_next = 1'b0;
    end
    // Writing zero to the power-down bit wakes the device
    if (wr_go && hit(avs_address, stc_pkg::OFF_POWER_CTRL)) begin
      power_down_next = avs_writedata[stc_pkg::PWR_DOWN_BIT];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      power_down_reg <= 1'b0;
    end else begin
      power_down_reg <= power_down_next;
    end
  end

  // Software reset is a one-cycle pulse
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      soft_reset_reg <= 1'b0;
    end else begin
      soft_reset_reg <= wr_go &&
                        hit(avs_address, stc_pkg::OFF_POWER_CTRL) &&
                        avs_writedata[stc_pkg::PWR_SOFT_RESET_BIT];
    end
  end

  // Interrupt events; a set in the cycle of a clear wins
  always_comb begin
    irq_set                          = '0;
    irq_set[stc_pkg::IRQ_READY_BIT]  = clock_ready_reg &&
                                       !clock_ready_prev_reg;
    irq_set[stc_pkg::IRQ_SWITCH_BIT] = busy_prev_reg && !clk_link.busy;
  end

  always_comb begin
    irq_clear = '0;
    if (wr_go && hit(avs_address, stc_pkg::OFF_IRQ_STATUS)) begin
      irq_clear = irq_field(avs_writedata, avs_byteenable);
    end
  end

  always_comb begin
    irq_status_next = (irq_status_reg & ~irq_clear) | irq_set;
    irq_mask_next   = irq_mask_reg;
    // Device reset drops masks and pending events
    if (dev_reset) begin
      irq_status_next = irq_set;
      irq_mask_next   = '0;
    end
    if (wr_go && hit(avs_address, stc_pkg::OFF_IRQ_MASK)) begin
      irq_mask_next = irq_field(avs_writedata, avs_byteenable);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_status_reg <= '0;
      irq_mask_reg   <= '0;
    end else begin
      irq_status_reg <= irq_status_next;
      irq_mask_reg   <= irq_mask_next;
    end
  end

  // Level interrupt, updated in the same cycle as its sources
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_status_next & irq_mask_next);
    end
  end

  // Read data multiplexer
  always_comb begin
    readdata_next = 32'h0;
    case (avs_address)
      stc_pkg::OFF_CLOCK_OUTPUT_PIN_CTRL: begin
        readdata_next[2:0] = clock_output_control_reg;
      end
      stc_pkg::OFF_MAIN_STATUS: begin
        readdata_next = status_word(clock_ready_reg, clk_link.busy,
                                    clk_link.active_sel);
      end
      stc_pkg::OFF_POWER_CTRL: begin
        readdata_next[stc_pkg::PWR_DOWN_BIT] = power_down_reg;
      end
      stc_pkg::OFF_IRQ_STATUS: begin
        readdata_next[stc_pkg::IRQ_W-1:0] = irq_status_reg;
      end
      stc_pkg::OFF_IRQ_MASK: begin
        readdata_next[stc_pkg::IRQ_W-1:0] = irq_mask_reg;
      end
      // Unmapped offsets read as zero
      default: begin
        readdata_next = 32'h0;
      end
    endcase
  end

  // One wait state: read data is taken while waitrequest is high,
  // then presented in the cycle that completes the transfer
  always_comb begin
    wait_next = 1'b1;
    if ((avs_read || avs_write) && !access_go) begin
      wait_next = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wait_reg     <= 1'b1;
      readdata_reg <= 32'h0;
    end else begin
      wait_reg <= wait_next;
      if (avs_read && wait_reg) begin
        readdata_reg <= readdata_next;
      end
    end
  end

  // Clock output generator
  assign clk_link.allow = allow_reg;
  assign clk_link.sel   = clock_output_control_reg;

  stc_clock_output_pin_gen gen_u (
    .clock (clock),
    .rst   (rst),
    .link  (clk_link.gen)
  );

  // Outputs straight from flip-flops
  assign avs_readdata     = readdata_reg;
  assign avs_waitrequest  = wait_reg;
  assign clock_output_pin = clk_link.pin;
  assign irq              = irq_reg;

endmodule

// >>> verilog/stc_pkg.sv
// Shared constants, register map and decode helpers for the clock block
package stc_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam int unsigned ADDR_W              = 5;
  localparam logic [4:0]  OFF_CLOCK_OUTPUT_PIN_CTRL     = 5'h00;
  localparam logic [4:0]  OFF_MAIN_STATUS     = 5'h04;
  localparam logic [4:0]  OFF_POWER_CTRL      = 5'h08;
  localparam logic [4:0]  OFF_IRQ_STATUS      = 5'h0c;
  localparam logic [4:0]  OFF_IRQ_MASK        = 5'h10;

  // Clock output select encodings
  localparam logic [2:0]  SEL_OFF             = 3'h0;
  localparam logic [2:0]  SEL_DIV1            = 3'h1;
  localparam logic [2:0]  SEL_DIV2            = 3'h2;
  localparam logic [2:0]  SEL_DIV3            = 3'h3;
  localparam logic [2:0]  SEL_DIV4            = 3'h4;
  localparam logic [2:0]  SEL_DIV8            = 3'h5;
  localparam logic [2:0]  SEL_RESET           = SEL_DIV4;

  // Field positions
  localparam int unsigned STAT_READY_BIT      = 0;
  localparam int unsigned STAT_BUSY_BIT       = 1;
  localparam int unsigned STAT_ACTIVE_LSB     = 2;
  localparam int unsigned PWR_DOWN_BIT        = 0;
  localparam int unsigned PWR_SOFT_RESET_BIT  = 1;
  localparam int unsigned IRQ_READY_BIT       = 0;
  localparam int unsigned IRQ_SWITCH_BIT      = 1;
  localparam int unsigned IRQ_W               = 2;

  // Timing: one oscillator period spans two system clocks
  localparam int unsigned CLOCK_HZ            = 10_000_000;
  localparam int unsigned CLOCKS_PER_OSC      = 2;
  localparam int unsigned STARTUP_OSC_CYCLES  = 7500;
  localparam int unsigned GAP_OSC_CYCLES      = 4;
  localparam logic [3:0]  GAP_CLOCKS          =
    4'(GAP_OSC_CYCLES * CLOCKS_PER_OSC);

  // Half period of the output, in system clocks, per select value
  function automatic logic [3:0] half_width(input logic [2:0] sel);
    case (sel)
      SEL_DIV1: half_width = 4'h1;
      SEL_DIV2: half_width = 4'h2;
      SEL_DIV3: half_width = 4'h3;
      SEL_DIV4: half_width = 4'h4;
      SEL_DIV8: half_width = 4'h8;
      default:  half_width = 4'h0;
    endcase
  endfunction

  function automatic logic is_test_sel(input logic [2:0] sel);
    is_test_sel = sel[2] & sel[1];
  endfunction

endpackage

// >>> verilog/stc_clk_if.sv
// Link between the control logic and the clock output generator
interface stc_clk_if;
  logic       allow;
  logic [2:0] sel;
  logic [2:0] active_sel;
  logic       busy;
  logic       pin;

  modport ctrl (output allow, sel, input active_sel, busy, pin);
  modport gen  (input allow, sel, output active_sel, busy, pin);
endinterface

// >>> verilog/stc_clock_output_pin_gen.sv
// Programmable clock output generator, glitch-free except when a test select cuts a phase
module stc_clock_output_pin_gen (
  // Clock and power-on reset
  input wire logic clock,
  input wire logic rst,
  // Control side
  stc_clk_if.gen   link
);

  typedef enum logic [1:0] {ST_HOLD, ST_RUN, ST_GAP} stc_gen_state_t;

  stc_gen_state_t state_reg;
  logic [3:0]     phase_cnt_reg;
  logic [3:0]     gap_cnt_reg;
  logic           out_reg;
  logic [2:0]     cur_reg;
  logic           sel_runs;

  assign sel_runs = (link.sel != stc_pkg::SEL_OFF) &&
                    !stc_pkg::is_test_sel(link.sel);

  // Phases finish before a switch, except a test select cuts one at once; no other sub-phase pulses
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg     <= ST_HOLD;
      phase_cnt_reg <= 4'h0;
      gap_cnt_reg   <= 4'h0;
      out_reg       <= 1'b0;
      cur_reg       <= stc_pkg::SEL_OFF;
    end else begin
      case (state_reg)
        ST_HOLD: begin
          out_reg <= 1'b0;
          // Every start passes through a full low gap
          if (link.allow) begin
            if (sel_runs) begin
              gap_cnt_reg <= 4'h0;
              state_reg   <= ST_GAP;
            end else begin
              cur_reg <= link.sel;
            end
          end
        end
        ST_RUN: begin
          if (stc_pkg::is_test_sel(link.sel)) begin
            out_reg   <= 1'b0;
            cur_reg   <= link.sel;
            state_reg <= ST_HOLD;
          end else if (phase_cnt_reg ==
                       stc_pkg::half_width(cur_reg) - 4'h1) begin
            phase_cnt_reg <= 4'h0;
            if (out_reg) begin
              out_reg <= 1'b0;
            end else if (link.sel != cur_reg) begin
              gap_cnt_reg <= 4'h0;
              state_reg   <= ST_GAP;
            end else begin
              out_reg <= 1'b1;
            end
          end else begin
            phase_cnt_reg <= phase_cnt_reg + 4'h1;
          end
        end
        ST_GAP: begin
          out_reg <= 1'b0;
          if (gap_cnt_reg == stc_pkg::GAP_CLOCKS - 4'h1) begin
            cur_reg <= link.sel;
            if (sel_runs) begin
              out_reg       <= 1'b1;
              phase_cnt_reg <= 4'h0;
              state_reg     <= ST_RUN;
            end else begin
              state_reg <= ST_HOLD;
            end
          end else begin
            gap_cnt_reg <= gap_cnt_reg + 4'h1;
          end
        end
        default: begin
          out_reg   <= 1'b0;
          state_reg <= ST_HOLD;
        end
      endcase
    end
  end

  assign link.pin        = out_reg;
  assign link.busy       = (state_reg == ST_GAP);
  assign link.active_sel = cur_reg;

endmodule

// >>> dv/stc_assertions.sv
// Port-level checks of the start-up timer and clock output
module stc_assertions #(
  parameter int unsigned STARTUP_OSC_CYCLES = 7500
) (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // Register bus
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  // Pins
  input wire logic        device_reset_n,
  input wire logic        clock_output_pin,
  input wire logic        irq
);
  localparam int S = STARTUP_OSC_CYCLES * stc_pkg::CLOCKS_PER_OSC;
  logic [15:0] up;
  logic [5:0]  wc;
  logic [4:0]  hi, lo;
  logic [2:0]  sel;
  logic [3:0]  hw;
  logic        wr_c, run;
  assign wr_c = avs_write && !avs_waitrequest
    && avs_address == stc_pkg::OFF_CLOCK_OUTPUT_PIN_CTRL;
  assign run = up > S + 40 && wc >= 40 && hw != 4'h0;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) up <= '0;
    else if (up != 16'hffff) up <= up + 16'h1;
  end
  // Shadow of the select field, kept only by power-on reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sel <= stc_pkg::SEL_RESET;
      wc <= '0;
    end else if (wr_c) begin
      sel <= avs_writedata[2:0];
      wc <= '0;
    end else if (wc != 6'h3f) wc <= wc + 6'h1;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hi <= '0;
      lo <= '0;
    end else begin
      hi <= clock_output_pin ? hi + 5'h1 : 5'h0;
      lo <= clock_output_pin ? 5'h0 : lo + 5'h1;
    end
  end
  always_comb begin
    case (sel)
      3'h1: hw = 4'h1;
      3'h2: hw = 4'h2;
      3'h3: hw = 4'h3;
      3'h4: hw = 4'h4;
      3'h5: hw = 4'h8;
      default: hw = 4'h0;
    endcase
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  held_low_a: assert property (up < S |-> !clock_output_pin)
    else $error("output toggled before start-up expiry");
  high_width_a: assert property ($fell(clock_output_pin) && run
    |-> hi == 5'(hw)) else $error("high phase width wrong");
  low_width_a: assert property ($rose(clock_output_pin) && run
    |-> lo == 5'(hw)) else $error("low phase width wrong");
  switch_gap_a: assert property (wr_c && avs_writedata[2:0] != sel
    && up > S + 40 |-> ##[1:24] !clock_output_pin [*4])
    else $error("no low gap after switch");
  off_low_a: assert property (sel == 3'h0 && wc >= 24
    |-> !clock_output_pin) else $error("disabled output not low");
  reset_run_a: assert property (run && !device_reset_n
    |-> ##[1:17] $changed(clock_output_pin))
    else $error("output stopped in device reset");
  bus_answer_a: assert property (avs_read || avs_write
    |-> ##[0:16] !avs_waitrequest) else $error("bus not answered");
  early_irq_a: assert property (up < S |-> !irq)
    else $error("interrupt before start-up expiry");
  cover property (run && $fell(clock_output_pin));
  cover property (sel == 3'h0 && wc >= 24);
  cover property (run && !device_reset_n);
endmodule

// >>> dv/stc_host_model.sv
// Host side: counts rising edges of the clock output
module stc_host_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Clock taken from the device
  input wire logic clock_output_pin,
  output int       edges
);
  logic last;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      last <= 1'b0;
      edges <= 0;
    end else begin
      last <= clock_output_pin;
      if (clock_output_pin && !last) edges <= edges + 1;
    end
  end
endmodule

// >>> dv/stc_tb.sv
// Register-level test of the clock block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, rst = 1, rd_s = 0, wr_s = 0, dr_n = 1, pin, irq, wq;
  logic [4:0] ad = '0;
  logic [31:0] wd = '0, rdat, v;
  logic a;
  int n_mismatch = 0, tests_run = 0, edges, e, cyc = 0, c0;
  always #50 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;
  stc_top #(.STARTUP_OSC_CYCLES(20)) dut_u (.clock, .rst,
    .avs_address(ad), .avs_read(rd_s), .avs_write(wr_s),
    .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdat),
    .avs_waitrequest(wq), .device_reset_n(dr_n),
    .clock_output_pin(pin), .irq);
  stc_host_model host_u (.clock, .rst, .clock_output_pin(pin), .edges);
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, s, x);
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [4:0] x, input int d);
    ad <= x;
    wd <= d;
    wr_s <= w;
    rd_s <= !w;
    do @(posedge clock); while (wq !== 1'b0);
    v = rdat;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wait_ready();
    repeat (200) begin
      acc(0, stc_pkg::OFF_MAIN_STATUS, 0);
      if (v[0] === 1'b1) return;
    end
    chk(v[0], 1);
  endtask
  initial begin
    #2000000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    c0 = cyc;
    acc(0, stc_pkg::OFF_MAIN_STATUS, 0);
    chk(v[0], 0);
    acc(0, stc_pkg::OFF_CLOCK_OUTPUT_PIN_CTRL, 0);
    chk(v[2:0], stc_pkg::SEL_RESET);
    wait_ready();
    chk(cyc - c0 >= 40, 1);
    e = edges;
    repeat (40) @(posedge clock);
    chk(edges > e, 1);
    for (int s = 1; s <= 5; s++) begin
      acc(1, stc_pkg::OFF_CLOCK_OUTPUT_PIN_CTRL, s);
      repeat (60) @(posedge clock);
      acc(0, stc_pkg::OFF_CLOCK_OUTPUT_PIN_CTRL, 0);
      chk(v[2:0], s);
    end
    acc(1, stc_pkg::OFF_CLOCK_OUTPUT_PIN_CTRL, 0);
    repeat (30) @(posedge clock);
    e = edges;
    repeat (20) @(posedge clock);
    chk({edges == e, pin}, 2'b10);
    acc(1, stc_pkg::OFF_CLOCK_OUTPUT_PIN_CTRL, 2);
    repeat (50) @(posedge clock);
    dr_n <= 1'b0;
    repeat (20) @(posedge clock);
    dr_n <= 1'b1;
    acc(1, stc_pkg::OFF_POWER_CTRL, 2);
    acc(0, stc_pkg::OFF_CLOCK_OUTPUT_PIN_CTRL, 0);
    chk(v[2:0], 2);
    acc(1, stc_pkg::OFF_POWER_CTRL, 1);
    e = edges;
    repeat (30) @(posedge clock);
    chk(edges > e, 1);
    acc(1, stc_pkg::OFF_POWER_CTRL, 0);
    acc(0, stc_pkg::OFF_MAIN_STATUS, 0);
    chk(v[0], 0);
    wait_ready();
    acc(0, stc_pkg::OFF_IRQ_STATUS, 0);
    chk(v[0], 1);
    acc(1, stc_pkg::OFF_IRQ_MASK, 0);
    a = irq;
    acc(1, stc_pkg::OFF_IRQ_MASK, 3);
    chk(a ^ irq, 1);
    acc(1, stc_pkg::OFF_IRQ_STATUS, 3);
    acc(0, stc_pkg::OFF_IRQ_STATUS, 0);
    chk({v[1:0], irq}, 3'h0);
    acc(1, stc_pkg::OFF_CLOCK_OUTPUT_PIN_CTRL, 6);
    repeat (30) @(posedge clock);
    e = edges;
    repeat (20) @(posedge clock);
    chk({edges == e, pin}, 2'b10);
    acc(0, 5'h1c, 0);
    chk(v, 0);
    finish_test();
  end
endmodule
bind stc_top stc_assertions #(.STARTUP_OSC_CYCLES(STARTUP_OSC_CYCLES))
  chk_u (.clock, .rst, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_waitrequest, .device_reset_n,
  .clock_output_pin, .irq);
